// ---- hw/failover_switch_config_decode.sv ----
// switch decode, remote-start output and sync indicator for the failover switcher
// What this block does
// - master mode rate from three-switch code
// - sync source: wordclock input or main pair
// - sync source ignored while sync master
// - two-switch sync mode, both on reserved
// - remote start follows monitored channel, default one
// - latched mode holds low until main or manual restore
// - momentary mode pulses low half second
// - momentary pulse repeats every ten seconds
// - lock loss immediate switch when enabled
// - otherwise lock loss counts as level loss
// - pair switch selects analogue or digital
// - ignore switch removes channel from detection
// - remote enable selects serial supplied settings
// - two-switch full scale code, reserved both
// - boot switch at power up enters boot
// - boot mode updates only via serial
// - sync led colour and flash on loss
`timescale 1ns/1ns
module failover_switch_config_decode #(
   parameter bit                    LATCH_WHEN_ON = 1'b1,
   parameter int unsigned           PULSE_LEN     = failover_cfg_pkg::PULSE_CYCLES,
   parameter int unsigned           REPEAT_LEN    = failover_cfg_pkg::REPEAT_CYCLES,
   parameter int unsigned           FLASH_LEN     = failover_cfg_pkg::FLASH_CYCLES
) (
   input  wire logic                       clk_i,
   input  wire logic                       rst_n_i,
   input  wire logic [11:0]                bank2_i,
   input  wire logic [11:0]                bank3_i,
   input  wire failover_cfg_pkg::cfg_t     remote_cfg_i,
   input  wire logic [2:0]                 monitor_chan_i,
   input  wire logic                       monitor_chan_wr_i,
   input  wire logic [7:0]                 chan_silent_i,
   input  wire logic                       backup_selected_i,
   input  wire logic                       manual_restore_i,
   input  wire logic                       backup_level_ok_i,
   input  wire logic                       sync_lost_i,
   output failover_cfg_pkg::cfg_t          cfg_o,
   output logic                            lock_switch_o,
   output logic                            lock_as_level_o,
   output logic [7:0]                      silence_mon_o,
   output logic                            start_silence_o,
   output logic                            remote_start_o,
   output logic                            remote_start_oe_o,
   output logic [1:0]                      sync_led_o,
   output logic                            boot_mode_o,
   output logic                            serial_update_en_o
);
   import failover_cfg_pkg::*;

   // switch synchronisers: three stages, change taken when stages 2 and 3 agree
   logic [23:0] sw_s1_reg, sw_s2_reg, sw_s3_reg, sw_reg;
   logic [23:0] sw_s1_next, sw_s2_next, sw_s3_next, sw_next;
   logic [1:0]  lost_s_reg, lost_s_next;
   logic        lost_s3_reg, lost_s3_next, lost_reg, lost_next;

   always_comb begin
      sw_s1_next   = {bank3_i, bank2_i};
      sw_s2_next   = sw_s1_reg;
      sw_s3_next   = sw_s2_reg;
      sw_next      = (sw_s2_reg == sw_s3_reg) ? sw_s3_reg : sw_reg;
      lost_s_next  = {lost_s_reg[0], sync_lost_i};
      lost_s3_next = lost_s_reg[1];
      lost_next    = (lost_s_reg[1] == lost_s3_reg) ? lost_s3_reg : lost_reg;
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sw_s1_reg   <= 24'h000000;
         sw_s2_reg   <= 24'h000000;
         sw_s3_reg   <= 24'h000000;
         sw_reg      <= 24'h000000;
         lost_s_reg  <= 2'h0;
         lost_s3_reg <= 1'b0;
         lost_reg    <= 1'b0;
      end else begin
         sw_s1_reg   <= sw_s1_next;
         sw_s2_reg   <= sw_s2_next;
         sw_s3_reg   <= sw_s3_next;
         sw_reg      <= sw_next;
         lost_s_reg  <= lost_s_next;
         lost_s3_reg <= lost_s3_next;
         lost_reg    <= lost_next;
      end
   end

   logic [11:0] b2, b3;
   assign b2 = sw_reg[11:0];
   assign b3 = sw_reg[23:12];

   // local switch decode
   cfg_t local_cfg;
   always_comb begin
      local_cfg.rate = rate_t'(b2[B2_RATE_LSB +: 3]);
      local_cfg.sync_mode = sync_mode_t'(b2[B2_MODE_LSB +: 2]);
      if (local_cfg.sync_mode == SYNC_MASTER) begin
         local_cfg.sync_src = SRC_INTERNAL;
      end else begin
         local_cfg.sync_src = b2[B2_SYNC_SRC] ? SRC_WORDCLOCK : SRC_MAIN_PAIR1;
      end
      local_cfg.lock_immediate = b2[B2_LOCK_FAIL];
      local_cfg.pair_analogue  = b2[B2_PAIR_LSB +: 4];
      local_cfg.monitor_en     = ~b3[B3_IGNORE_LSB +: 8];
      local_cfg.remote_ctrl    = b3[B3_REMOTE_EN];
      local_cfg.full_scale     = full_scale_t'(b3[B3_FS_LSB +: 2]);
   end

   // registered configuration, remote-supplied when enabled
   cfg_t cfg_reg, cfg_next;
   logic lock_sw_reg, lock_sw_next, lock_lvl_reg, lock_lvl_next;
   logic [7:0] mon_reg, mon_next;
   always_comb begin
      cfg_next = b3[B3_REMOTE_EN] ? remote_cfg_i : local_cfg;
      cfg_next.remote_ctrl = b3[B3_REMOTE_EN];
      lock_sw_next  = lost_reg && cfg_next.lock_immediate;
      lock_lvl_next = lost_reg && !cfg_next.lock_immediate;
      mon_next      = cfg_next.monitor_en;
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cfg_reg      <= '0;
         lock_sw_reg  <= 1'b0;
         lock_lvl_reg <= 1'b0;
         mon_reg      <= 8'h00;
      end else begin
         cfg_reg      <= cfg_next;
         lock_sw_reg  <= lock_sw_next;
         lock_lvl_reg <= lock_lvl_next;
         mon_reg      <= mon_next;
      end
   end

   assign cfg_o           = cfg_reg;
   assign lock_switch_o   = lock_sw_reg;
   assign lock_as_level_o = lock_lvl_reg;
   assign silence_mon_o   = mon_reg;

   // boot strap caught once, after reset release, once the filter has settled
   logic       boot_reg, boot_next, boot_done_reg, boot_done_next;
   logic [2:0] boot_wait_reg, boot_wait_next;
   always_comb begin
      boot_wait_next = boot_wait_reg;
      boot_done_next = boot_done_reg;
      boot_next      = boot_reg;
      if (!boot_done_reg) begin
         // wait for the filtered value, the reset zero would be caught otherwise
         if (boot_wait_reg == 3'h4) begin
            boot_next      = sw_reg[12 + B3_BOOT];
            boot_done_next = 1'b1;
         end else begin
            boot_wait_next = boot_wait_reg + 3'h1;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         boot_reg      <= 1'b0;
         boot_done_reg <= 1'b0;
         boot_wait_reg <= 3'h0;
      end else begin
         boot_reg      <= boot_next;
         boot_done_reg <= boot_done_next;
         boot_wait_reg <= boot_wait_next;
      end
   end

   assign boot_mode_o        = boot_reg;
   assign serial_update_en_o = boot_reg;

   // monitored channel for remote start, serial reassignable
   logic [2:0] chan_reg, chan_next;
   logic       start_sil_reg, start_sil_next;
   always_comb begin
      chan_next      = monitor_chan_wr_i ? monitor_chan_i : chan_reg;
      start_sil_next = chan_silent_i[chan_reg];
   end

   // remote start sequencer
   typedef enum logic [1:0] {RS_IDLE, RS_PULSE, RS_WAIT, RS_LATCH} rs_state_t;
   rs_state_t        rs_reg, rs_next;
   logic [CNT_W-1:0] cnt_reg, cnt_next;
   logic             bk_d_reg, bk_d_next;
   logic             start_low_reg, start_low_next;
   logic             latched;
   logic             bk_rise;

   // latched vs momentary polarity unclear, so it is a parameter
   assign latched = (b2[B2_START_MODE] == LATCH_WHEN_ON);
   assign bk_rise = backup_selected_i && !bk_d_reg;

   always_comb begin
      rs_next   = rs_reg;
      cnt_next  = cnt_reg;
      bk_d_next = backup_selected_i;
      case (rs_reg)
         RS_IDLE: begin
            if (bk_rise) begin
               cnt_next = '0;
               rs_next  = latched ? RS_LATCH : RS_PULSE;
            end
         end
         RS_LATCH: begin
            if (!backup_selected_i || manual_restore_i) begin
               rs_next = RS_IDLE;
            end
         end
         RS_PULSE: begin
            cnt_next = cnt_reg + 1'b1;
            if (cnt_reg == CNT_W'(PULSE_LEN - 1)) begin
               rs_next = RS_WAIT;
            end
         end
         RS_WAIT: begin
            cnt_next = cnt_reg + 1'b1;
            if (!backup_selected_i || backup_level_ok_i) begin
               rs_next = RS_IDLE;
            end else if (cnt_reg == CNT_W'(REPEAT_LEN - 1)) begin
               cnt_next = '0;
               rs_next  = RS_PULSE;
            end
         end
         default: rs_next = RS_IDLE;
      endcase
      start_low_next = (rs_next == RS_PULSE) || (rs_next == RS_LATCH);
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rs_reg        <= RS_IDLE;
         cnt_reg       <= '0;
         bk_d_reg      <= 1'b0;
         start_low_reg <= 1'b0;
         chan_reg      <= CHAN_DEFAULT[2:0];
         start_sil_reg <= 1'b0;
      end else begin
         rs_reg        <= rs_next;
         cnt_reg       <= cnt_next;
         bk_d_reg      <= bk_d_next;
         start_low_reg <= start_low_next;
         chan_reg      <= chan_next;
         start_sil_reg <= start_sil_next;
      end
   end

   // open collector: pull low only, never drive high
   assign remote_start_o    = 1'b0;
   assign remote_start_oe_o = start_low_reg;
   assign start_silence_o   = start_sil_reg;

   // sync indicator with flash timer
   logic [CNT_W-1:0] fl_cnt_reg, fl_cnt_next;
   logic             fl_reg, fl_next;
   logic [1:0]       led_reg, led_next;
   always_comb begin
      fl_cnt_next = fl_cnt_reg + 1'b1;
      fl_next     = fl_reg;
      if (fl_cnt_reg == CNT_W'(FLASH_LEN - 1)) begin
         fl_cnt_next = '0;
         fl_next     = !fl_reg;
      end
      case (cfg_reg.sync_mode)
         SYNC_MASTER: led_next = LED_GREEN;
         SYNC_SLAVE:  led_next = (lost_reg && fl_reg) ? LED_OFF : LED_YELLOW;
         SYNC_AUTO:   led_next = (lost_reg && fl_reg) ? LED_OFF : LED_RED;
         default:     led_next = LED_OFF;
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         fl_cnt_reg <= '0;
         fl_reg     <= 1'b0;
         led_reg    <= LED_OFF;
      end else begin
         fl_cnt_reg <= fl_cnt_next;
         fl_reg     <= fl_next;
         led_reg    <= led_next;
      end
   end

   assign sync_led_o = led_reg;

   // assertions
   sequence s_backup_edge;
      backup_selected_i && !bk_d_reg && rs_reg == RS_IDLE;
   endsequence

   a_pulse_start: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (s_backup_edge and !latched) |=> remote_start_oe_o)
      else $error("momentary pulse did not start");

   a_latch_start: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (s_backup_edge and latched) |=> remote_start_oe_o && rs_reg == RS_LATCH)
      else $error("latched output did not go low");

   a_latch_release: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      rs_reg == RS_LATCH && !backup_selected_i |=> !remote_start_oe_o)
      else $error("latched output not released on main");

   a_pulse_end: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      rs_reg == RS_PULSE && cnt_reg == CNT_W'(PULSE_LEN - 1) |=> !remote_start_oe_o)
      else $error("pulse did not end");

   a_repeat_pulse: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      rs_reg == RS_WAIT && cnt_reg == CNT_W'(REPEAT_LEN - 1) && backup_selected_i
      && !backup_level_ok_i |=> remote_start_oe_o)
      else $error("repeat pulse missing");

   a_src_master: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      !b3[B3_REMOTE_EN] && b2[B2_MODE_LSB +: 2] == 2'h0 |=> cfg_o.sync_src == SRC_INTERNAL)
      else $error("sync source used in master");

   a_rate_decode: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      !b3[B3_REMOTE_EN] |=> cfg_o.rate == $past(b2[2:0]))
      else $error("rate decode wrong");

   a_lock_split: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      !(lock_switch_o && lock_as_level_o))
      else $error("lock loss routed both ways");

   a_monitor_map: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      !b3[B3_REMOTE_EN] |=> silence_mon_o == ~$past(b3[7:0]))
      else $error("ignore mapping wrong");

   a_master_led: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      cfg_reg.sync_mode == SYNC_MASTER |=> sync_led_o == LED_GREEN)
      else $error("master led not green");

   a_pair_map: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      !b3[B3_REMOTE_EN] |=> cfg_o.pair_analogue == $past(b2[B2_PAIR_LSB +: 4]))
      else $error("pair output mapping wrong");

   a_fs_decode: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      !b3[B3_REMOTE_EN] |=> cfg_o.full_scale == $past(b3[B3_FS_LSB +: 2]))
      else $error("full scale decode wrong");

   a_remote_sel: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      b3[B3_REMOTE_EN] |=> cfg_o.remote_ctrl && cfg_o.rate == $past(remote_cfg_i.rate))
      else $error("remote settings not taken");

   a_boot_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      boot_done_reg |=> $stable(boot_mode_o))
      else $error("boot mode changed after capture");

endmodule : failover_switch_config_decode

// ---- hw/failover_cfg_pkg.sv ----
// constants and types for the failover switcher configuration decode
package failover_cfg_pkg;

   localparam int unsigned CLK_HZ            = 50_000_000;
   localparam int unsigned PULSE_MS          = 500;
   localparam int unsigned REPEAT_S          = 10;
   localparam int unsigned PULSE_CYCLES      = CLK_HZ / 1000 * PULSE_MS;
   localparam int unsigned REPEAT_CYCLES     = CLK_HZ * REPEAT_S;
   localparam int unsigned FLASH_CYCLES      = CLK_HZ / 4;
   localparam int unsigned CNT_W             = 32;

   // bank 2 field positions
   localparam int unsigned B2_RATE_LSB       = 0;
   localparam int unsigned B2_SYNC_SRC       = 3;
   localparam int unsigned B2_MODE_LSB       = 4;
   localparam int unsigned B2_START_MODE     = 6;
   localparam int unsigned B2_LOCK_FAIL      = 7;
   localparam int unsigned B2_PAIR_LSB       = 8;
   // bank 3 field positions
   localparam int unsigned B3_IGNORE_LSB     = 0;
   localparam int unsigned B3_REMOTE_EN      = 8;
   localparam int unsigned B3_FS_LSB         = 9;
   localparam int unsigned B3_BOOT           = 11;

   localparam logic [3:0] CHAN_DEFAULT       = 4'h0;
   localparam logic [1:0] LED_OFF            = 2'h0;
   localparam logic [1:0] LED_GREEN          = 2'h1;
   localparam logic [1:0] LED_YELLOW         = 2'h2;
   localparam logic [1:0] LED_RED            = 2'h3;

   typedef enum logic [2:0] {
      RATE_32K, RATE_44K1, RATE_48K, RATE_88K2,
      RATE_96K, RATE_176K4, RATE_192K, RATE_NONE
   } rate_t;

   typedef enum logic [1:0] {
      SYNC_MASTER, SYNC_AUTO, SYNC_SLAVE, SYNC_RESERVED
   } sync_mode_t;

   typedef enum logic [1:0] {
      FS_24DBU, FS_18DBU, FS_12DBU, FS_RESERVED
   } full_scale_t;

   typedef enum logic [1:0] {
      SRC_INTERNAL, SRC_WORDCLOCK, SRC_MAIN_PAIR1
   } sync_src_t;

   typedef struct packed {
      rate_t       rate;
      sync_mode_t  sync_mode;
      sync_src_t   sync_src;
      logic        lock_immediate;
      logic [3:0]  pair_analogue;
      logic [7:0]  monitor_en;
      logic        remote_ctrl;
      full_scale_t full_scale;
   } cfg_t;

endpackage : failover_cfg_pkg

// ---- testbench/start_equipment_model.sv ----
// model of the equipment started by the remote-start line
`timescale 1ns/1ns
module start_equipment_model (
   input  wire logic       clk_i,
   input  wire logic       start_line_i,
   output logic [7:0]      starts_o,
   output logic [7:0]      low_len_o
);
   logic       line_reg    = 1'b1;
   logic [7:0] run_reg     = 8'h00;
   logic [7:0] starts_reg  = 8'h00;
   logic [7:0] low_len_reg = 8'h00;
   assign starts_o  = starts_reg;
   assign low_len_o = low_len_reg;
   // a start is a falling line; width of each low spell kept to judge pulses
   always @(posedge clk_i) begin
      line_reg <= start_line_i;
      if (!start_line_i)
         run_reg <= run_reg + 8'h01;
      else
         run_reg <= 8'h00;
      if (line_reg && !start_line_i)
         starts_reg <= starts_reg + 8'h01;
      if (!line_reg && start_line_i)
         low_len_reg <= run_reg;
   end
endmodule : start_equipment_model

// ---- testbench/test_failover_switch_config_decode.sv ----
// self-checking bench for the failover switch configuration decode
`timescale 1ns/1ns
`define CHECK(nm, exp, got) \
   begin \
      checked++; \
      if ((got) !== (exp)) begin \
         miscompares++; \
         $display("[FAIL] %s expected %h seen %h", nm, exp, got); \
      end \
   end
module test_failover_switch_config_decode;
   import failover_cfg_pkg::*;
   localparam int PL = 4;
   localparam int RL = 20;
   logic        clk_i = 1'b0;
   logic        rst_n_i = 1'b0;
   logic [11:0] bank2_i = 12'h000;
   logic [11:0] bank3_i = 12'h000;
   cfg_t        remote_cfg_i = '0;
   logic [2:0]  monitor_chan_i = 3'h0;
   logic        monitor_chan_wr_i = 1'b0;
   logic [7:0]  chan_silent_i = 8'h00;
   logic        backup_selected_i = 1'b0;
   logic        manual_restore_i = 1'b0;
   logic        backup_level_ok_i = 1'b0;
   logic        sync_lost_i = 1'b0;
   cfg_t        cfg_o;
   logic        lock_switch_o;
   logic        lock_as_level_o;
   logic [7:0]  silence_mon_o;
   logic        start_silence_o;
   logic        remote_start_o;
   logic        remote_start_oe_o;
   logic [1:0]  sync_led_o;
   logic        boot_mode_o;
   logic        serial_update_en_o;
   logic [7:0]  starts;
   logic [7:0]  low_len;
   int          miscompares = 0;
   int          checked = 0;
   int          cycles = 0;
   // open collector with pull-up: released line reads high
   wire         start_line = remote_start_oe_o ? remote_start_o : 1'b1;

   failover_switch_config_decode #(.PULSE_LEN(PL), .REPEAT_LEN(RL), .FLASH_LEN(3))
   failover_switch_config_decode_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .bank2_i(bank2_i),
      .bank3_i(bank3_i), .remote_cfg_i(remote_cfg_i), .monitor_chan_i(monitor_chan_i),
      .monitor_chan_wr_i(monitor_chan_wr_i), .chan_silent_i(chan_silent_i),
      .backup_selected_i(backup_selected_i), .manual_restore_i(manual_restore_i),
      .backup_level_ok_i(backup_level_ok_i), .sync_lost_i(sync_lost_i), .cfg_o(cfg_o),
      .lock_switch_o(lock_switch_o), .lock_as_level_o(lock_as_level_o),
      .silence_mon_o(silence_mon_o), .start_silence_o(start_silence_o),
      .remote_start_o(remote_start_o), .remote_start_oe_o(remote_start_oe_o),
      .sync_led_o(sync_led_o), .boot_mode_o(boot_mode_o),
      .serial_update_en_o(serial_update_en_o));

   start_equipment_model start_equipment_model_inst (.clk_i(clk_i),
      .start_line_i(start_line), .starts_o(starts), .low_len_o(low_len));

   initial begin
      forever #10 clk_i = ~clk_i;
   end

   task automatic wait_n(input int n);
      repeat (n) @(negedge clk_i);
   endtask : wait_n

   task automatic conclude;
      $display("comparisons %0d mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : conclude

   task automatic do_reset;
      rst_n_i = 1'b0;
      wait_n(10);
      rst_n_i = 1'b1;
      wait_n(8);
   endtask : do_reset

   task automatic t_rate;
      for (int c = 0; c < 8; c++) begin
         bank2_i = {8'h00, 1'(c), 3'(c)};
         wait_n(8);
         `CHECK("rate", rate_t'(c), cfg_o.rate);
         `CHECK("src master", SRC_INTERNAL, cfg_o.sync_src);
      end
      $display("test rate done");
   endtask : t_rate

   task automatic t_mode;
      logic [1:0] led [4];
      led = '{LED_GREEN, LED_RED, LED_YELLOW, LED_OFF};
      for (int m = 0; m < 4; m++) begin
         for (int s = 0; s < 2; s++) begin
            bank2_i = {6'h00, 2'(m), 1'(s), 3'h0};
            wait_n(8);
            `CHECK("mode", sync_mode_t'(m), cfg_o.sync_mode);
            `CHECK("led", led[m], sync_led_o);
            if (m == 1 || m == 2)
               `CHECK("src", s ? SRC_WORDCLOCK : SRC_MAIN_PAIR1, cfg_o.sync_src);
         end
      end
      $display("test mode done");
   endtask : t_mode

   task automatic t_lock;
      int n_off;
      int n_on;
      for (int k = 0; k < 2; k++) begin
         bank2_i = {4'h0, 1'(k), 7'h00};
         sync_lost_i = 1'b1;
         wait_n(8);
         `CHECK("lock imm", 1'(k), lock_switch_o);
         `CHECK("lock lvl", 1'(!k), lock_as_level_o);
         sync_lost_i = 1'b0;
         wait_n(8);
         `CHECK("lock clr", 1'b0, lock_switch_o | lock_as_level_o);
      end
      // auto and slave with lock lost must flash their colour; master stays steady
      sync_lost_i = 1'b1;
      for (int m = 1; m < 3; m++) begin
         bank2_i = {6'h00, 2'(m), 4'h0};
         wait_n(8);
         n_off = 0;
         n_on = 0;
         for (int i = 0; i < 12; i++) begin
            wait_n(1);
            n_off += (sync_led_o === LED_OFF);
            n_on += (sync_led_o === ((m == 1) ? LED_RED : LED_YELLOW));
         end
         `CHECK("flash", 1'b1, n_off > 0 && n_off < 12);
         `CHECK("flash colour", 12, n_off + n_on);
      end
      bank2_i = 12'h000;
      wait_n(8);
      `CHECK("steady", LED_GREEN, sync_led_o);
      sync_lost_i = 1'b0;
      $display("test lock done");
   endtask : t_lock

   task automatic t_misc;
      cfg_t e;
      bank2_i = 12'hA00;
      for (int f = 0; f < 4; f++) begin
         bank3_i = {1'b0, 2'(f), 1'b0, 8'h35};
         wait_n(8);
         `CHECK("pairs", 4'hA, cfg_o.pair_analogue);
         `CHECK("level mode", 1'b0, cfg_o.lock_immediate);
         `CHECK("mon", 8'hCA, cfg_o.monitor_en);
         `CHECK("mon out", 8'hCA, silence_mon_o);
         `CHECK("fs", full_scale_t'(f), cfg_o.full_scale);
      end
      e = '{RATE_96K, SYNC_SLAVE, SRC_WORDCLOCK, 1'b1, 4'h5, 8'h3C, 1'b0, FS_12DBU};
      remote_cfg_i = e;
      bank3_i = 12'h100;
      wait_n(8);
      e.remote_ctrl = 1'b1;
      `CHECK("remote", e, cfg_o);
      `CHECK("rmon", 8'h3C, silence_mon_o);
      bank3_i = 12'h000;
      bank2_i = 12'h000;
      wait_n(8);
      $display("test misc done");
   endtask : t_misc

   task automatic t_monitor;
      chan_silent_i = 8'h01;
      wait_n(4);
      `CHECK("ch1", 1'b1, start_silence_o);
      monitor_chan_i = 3'h5;
      monitor_chan_wr_i = 1'b1;
      wait_n(1);
      monitor_chan_wr_i = 1'b0;
      wait_n(4);
      `CHECK("ch1 off", 1'b0, start_silence_o);
      chan_silent_i = 8'h20;
      wait_n(4);
      `CHECK("ch6", 1'b1, start_silence_o);
      chan_silent_i = 8'h00;
      $display("test monitor done");
   endtask : t_monitor

   task automatic t_momentary;
      logic [7:0] s0;
      s0 = starts;
      backup_selected_i = 1'b1;
      wait_n(PL + 3);
      `CHECK("pulse", 8'(PL), low_len);
      `CHECK("one start", s0 + 8'h01, starts);
      wait_n(RL + PL + 4);
      `CHECK("repeat", s0 + 8'h02, starts);
      `CHECK("rpulse", 8'(PL), low_len);
      backup_level_ok_i = 1'b1;
      wait_n(RL + PL + 8);
      `CHECK("stop", s0 + 8'h02, starts);
      backup_selected_i = 1'b0;
      backup_level_ok_i = 1'b0;
      wait_n(2);
      $display("test momentary done");
   endtask : t_momentary

   task automatic t_latched;
      bank2_i = 12'h040;
      wait_n(8);
      backup_selected_i = 1'b1;
      wait_n(RL + 10);
      `CHECK("held", 1'b0, start_line);
      backup_selected_i = 1'b0;
      wait_n(3);
      `CHECK("main", 1'b1, start_line);
      backup_selected_i = 1'b1;
      wait_n(5);
      `CHECK("held2", 1'b0, start_line);
      manual_restore_i = 1'b1;
      wait_n(1);
      manual_restore_i = 1'b0;
      wait_n(3);
      `CHECK("restore", 1'b1, start_line);
      backup_selected_i = 1'b0;
      bank2_i = 12'h000;
      wait_n(8);
      $display("test latched done");
   endtask : t_latched

   task automatic t_boot;
      bank3_i = 12'h800;
      do_reset();
      `CHECK("boot", 1'b1, boot_mode_o);
      `CHECK("serial", 1'b1, serial_update_en_o);
      bank3_i = 12'h000;
      wait_n(8);
      `CHECK("boot kept", 1'b1, boot_mode_o);
      do_reset();
      `CHECK("normal", 1'b0, boot_mode_o | serial_update_en_o);
      $display("test boot done");
   endtask : t_boot

   // ceiling well above the few hundred cycles the tests need
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 5000) begin
         miscompares++;
         conclude();
      end
   end

   initial begin
      do_reset();
      t_monitor();
      t_rate();
      t_mode();
      t_lock();
      t_misc();
      t_momentary();
      t_latched();
      t_boot();
      conclude();
   end
endmodule : test_failover_switch_config_decode
